// ==== src/monitor_cfg.svh ====
// Purpose: Bit positions, reset values and timing for the status/config block.
// Assumes: One 250 MHz clock.
// Notes:   Shared by the top and the pulse generator.
`ifndef MONITOR_CFG_SVH
`define MONITOR_CFG_SVH

// Status/configuration word, 16 bits
`define SCR_WIDTH          16
`define SCR_RESET_DONE_FLAG_BIT       14
`define SCR_CONV_DATA_READY_FLAG_BIT       13
`define SCR_ZERO_BIT       12
`define SCR_EXT_REF_SELECT_BIT       7
`define SCR_INT_REF_GAIN_SELECT_BIT       6
`define SCR_EXT_TRIGGER_ENABLE_BIT      5

// Reset values
`define SCR_RESET_DONE_FLAG_RST       1'b1
`define SCR_CONV_DATA_READY_FLAG_RST       1'b0
`define SCR_EXT_REF_SELECT_RST       1'b0
`define SCR_INT_REF_GAIN_SELECT_RST       1'b0
`define SCR_EXT_TRIGGER_ENABLE_RST      1'b0
`define CONV_REPEAT_MODE_RST          1'b0

// ADC control word fields
`define ACR_CONV_REPEAT_MODE_BIT      15
`define ACR_FIRST_LSB      8
`define ACR_LAST_LSB       4

// Timing
`define CLK_FREQ_MHZ       250
`define DRDY_PULSE_NS      2000
`define DRDY_PULSE_CYC     ((`DRDY_PULSE_NS * `CLK_FREQ_MHZ) / 1000)

`endif

// ==== src/monitor_pkg.sv ====
// Purpose: Types shared by the status/config block and its sequencer.
// Assumes: Constants live in monitor_cfg.svh.
// Notes:   One-hot state codes.
package monitor_pkg;

    typedef logic [3:0] chan_t;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b01,
        SEQ_BUSY = 2'b10
    } seq_state_e;

    // Next channel address, wraps at the top of the range
    function automatic chan_t next_chan(input chan_t c);
        next_chan = chan_t'(c + 4'h1);
    endfunction : next_chan

endpackage : monitor_pkg

// ==== src/seq_if.sv ====
// Purpose: Carrier between the register block and the channel sequencer.
// Assumes: Single clock domain.
// Notes:   None.
`timescale 1ns/1ps
`default_nettype none
interface seq_if;
    import monitor_pkg::*;
    logic  trig;
    logic  abort;
    logic  auto_mode;
    chan_t first;
    chan_t last;
    logic  chan_done;
    logic  start;
    chan_t chan;
    logic  set_done;

    modport ctrl (output trig, abort, auto_mode, first, last, chan_done,
                  input start, chan, set_done);
    modport seq  (input trig, abort, auto_mode, first, last, chan_done,
                  output start, chan, set_done);
endinterface : seq_if
`default_nettype wire

// ==== src/conv_sequencer.sv ====
// Purpose: Steps the ADC through the first..last channel group.
// Assumes: ADC reports each finished channel with a one-cycle pulse.
// Notes:   A trigger while busy restarts the group from the first channel.
`timescale 1ns/1ps
`default_nettype none
module conv_sequencer
    import monitor_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    // To the register block
    seq_if.seq        sq
);
    seq_state_e state_q;
    logic       at_last;

    assign at_last = (sq.chan == sq.last);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_q     <= SEQ_IDLE;
            sq.chan     <= 4'h0;
            sq.start    <= 1'b0;
            sq.set_done <= 1'b0;
        end else begin
            sq.start    <= 1'b0;
            sq.set_done <= 1'b0;
            case (state_q)
                SEQ_IDLE: begin
                    if (sq.trig) begin
                        sq.chan  <= sq.first;  // see R16
                        sq.start <= 1'b1;
                        state_q  <= SEQ_BUSY;
                    end
                end
                SEQ_BUSY: begin
                    if (sq.abort) begin
                        state_q <= SEQ_IDLE;
                    end else if (sq.trig) begin
                        sq.chan  <= sq.first;
                        sq.start <= 1'b1;
                    end else if (sq.chan_done) begin
                        if (at_last) begin
                            sq.set_done <= 1'b1;
                            if (sq.auto_mode) begin
                                sq.chan  <= sq.first;
                                sq.start <= 1'b1;
                            end else begin
                                state_q <= SEQ_IDLE;  // see R16
                            end
                        end else begin
                            sq.chan  <= next_chan(sq.chan);
                            sq.start <= 1'b1;
                        end
                    end
                end
                default: state_q <= SEQ_IDLE;
            endcase
        end
    end

    sequence last_done_direct;
        state_q == SEQ_BUSY && sq.chan_done && at_last && !sq.abort && !sq.trig && !sq.auto_mode;
    endsequence

    seq_goes_idle_a: assert property (  // see R16
        @(posedge clk) disable iff (!reset_n)
        last_done_direct |=> (state_q == SEQ_IDLE && sq.set_done && !sq.start))
        else $error("Direct group did not stop after last channel");

    seq_first_chan_a: assert property (  // see R16
        @(posedge clk) disable iff (!reset_n)
        (sq.trig && !sq.abort) |=> (sq.start && sq.chan == $past(sq.first)))
        else $error("Trigger did not start at first channel");

endmodule : conv_sequencer
`default_nettype wire

// ==== src/drdy_pulse_gen.sv ====
// Purpose: Fixed-width low pulse timer for the data-ready pin in auto mode.
// Assumes: Fire is a one-cycle pulse.
// Notes:   A new fire restarts the full width.
`timescale 1ns/1ps
`default_nettype none
`include "monitor_cfg.svh"
module drdy_pulse_gen #(
    parameter int unsigned WIDTH_CYC = `DRDY_PULSE_CYC
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    // Control
    input  wire logic fire,
    output logic      active
);
    localparam int unsigned CW = $clog2(WIDTH_CYC + 1);
    localparam logic [CW-1:0] LOAD = CW'(WIDTH_CYC);

    logic [CW-1:0] cnt_q;

    assign active = (cnt_q != '0);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cnt_q <= '0;
        end else if (fire) begin
            cnt_q <= LOAD;  // see R9
        end else if (active) begin
            cnt_q <= cnt_q - CW'(1);
        end
    end

endmodule : drdy_pulse_gen
`default_nettype wire

// ==== src/monitor_status_config_regs.sv ====
// Purpose: Status/configuration register, reset behaviour and data-ready pin.
// Assumes: Serial framing is decoded outside; accesses arrive as word strobes.
// Notes:   In direct mode the pin follows the flag one cycle late (registered output); in auto mode it follows the pulse timer.
//
// What this block does
// R1 - Any reset returns every software-visible register to its default.
// R2 - Resets never touch the DAC input shift register; only registers reset.
// R3 - Host keeps slave-select deasserted during power-up, ideally via pull-up.
// R4 - After reset everything stays powered down until host writes power-down.
// R5 - Reset-done flag bit 14 sets on reset; write 0 clears, 1 keeps.
// R6 - Direct mode: data-ready flag bit 13 is 1 when group done, else 0.
// R7 - Auto mode: data-ready flag is always zero.
// R8 - Direct mode: data-ready pin low when flag is 1, high when 0.
// R9 - Auto mode: 2us low pulse on pin after last channel converts.
// R10 - Flag clears on data read, new conversion start, or writing zero.
// R11 - Bit 12 is read-only and always reads zero.
// R12 - Bit 7 zero picks internal reference; one disconnects it for external.
// R13 - Bit 6 picks 1.25V or 2.5V internal; ignored with external reference.
// R14 - Reference select and gain also go to the current source.
// R15 - Bit 5 set: trigger pin rising edge starts; control writes only select.
// R16 - External trigger converts first..last channel once, then idles.
// R17 - Bit 5 clear: trigger pin ignored; each control write starts conversion.
// R18 - External trigger forces direct mode; else repeat bit picks direct/auto.
// R19 - Reset: flag, reference bits, trigger enable zero; reset-done one.
// R20 - Repeat bit forced zero when external trigger enabled; auto repeats.
// R21 - Don't-care bits ignore writes and read as zero.
`timescale 1ns/1ps
`default_nettype none
`include "monitor_cfg.svh"
module monitor_status_config_regs
    import monitor_pkg::*;
#(
    parameter int unsigned DRDY_PULSE_CYC = `DRDY_PULSE_CYC
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // Status/configuration word access
    input  wire logic        scr_wr,
    input  wire logic [15:0] scr_wdata,
    output logic      [15:0] scr_rdata_q,
    // Other register events from the serial decoder
    input  wire logic        adc_ctrl_wr,
    input  wire logic [15:0] adc_ctrl_wdata,
    input  wire logic        adc_data_rd,
    input  wire logic        pd_reg_wr,
    // Trigger pin and ADC handshake
    input  wire logic        convert_pin,
    input  wire logic        adc_chan_done,
    output logic             adc_start_q,
    output logic      [3:0]  adc_chan_q,
    // Pins and analog controls
    output logic             data_ready_pin_n,
    output logic             ext_ref_select,
    output logic             int_ref_gain_select,
    output logic      [1:0]  isrc_ref_cfg_q,
    output logic             powered_down_q
);
    // Register bits
    logic  reset_done_flag_q;
    logic  conv_data_ready_flag_q;
    logic  ext_ref_select_q;
    logic  int_ref_gain_select_q;
    logic  ext_trigger_enable_q;
    logic  conv_repeat_mode_q;
    chan_t first_channel_addr_q;
    chan_t last_channel_addr_q;
    logic  convert_pin_q;
    logic  drdy_pin_q;

    // Decode
    logic  ext_edge;
    logic  int_trig;
    logic  conv_trig;
    logic  auto_mode;
    logic  flag_set;
    logic  flag_clr;
    logic  flag_d;
    logic  reset_done_flag_d;
    logic  pulse_fire;
    logic  pulse_active;
    logic  ext_en_rise;
    logic  [15:0] scr_word;
    chan_t wr_first;

    seq_if sq ();

    assign ext_edge    = ext_trigger_enable_q && convert_pin && !convert_pin_q;  // see R15
    assign int_trig    = adc_ctrl_wr && !ext_trigger_enable_q;                   // see R17
    assign conv_trig   = ext_edge || int_trig;
    assign auto_mode   = !ext_trigger_enable_q && conv_repeat_mode_q;            // see R18
    assign ext_en_rise = scr_wr && scr_wdata[`SCR_EXT_TRIGGER_ENABLE_BIT] && !ext_trigger_enable_q;

    // Done pulse only sets the flag for a direct-mode group
    assign flag_set   = sq.set_done && !auto_mode;                               // see R6
    assign flag_clr   = adc_data_rd || conv_trig ||
                        (scr_wr && !scr_wdata[`SCR_CONV_DATA_READY_FLAG_BIT]);                   // see R10
    // Set beats a simultaneous clear so a finished group is never lost
    assign flag_d     = auto_mode ? 1'b0 :                                       // see R7
                        (flag_set || (conv_data_ready_flag_q && !flag_clr));
    assign reset_done_flag_d     = reset_done_flag_q &&
                        !(scr_wr && !scr_wdata[`SCR_RESET_DONE_FLAG_BIT]);                  // see R5
    assign pulse_fire = sq.set_done && auto_mode;                                // see R9

    // Unlisted and bit 12 positions read as zero
    assign scr_word = (16'h0001 << `SCR_RESET_DONE_FLAG_BIT)  & {16{reset_done_flag_q}}      |
                      (16'h0001 << `SCR_CONV_DATA_READY_FLAG_BIT)  & {16{conv_data_ready_flag_q}} |
                      (16'h0001 << `SCR_EXT_REF_SELECT_BIT)  & {16{ext_ref_select_q}}       |
                      (16'h0001 << `SCR_INT_REF_GAIN_SELECT_BIT)  & {16{int_ref_gain_select_q}}  |
                      (16'h0001 << `SCR_EXT_TRIGGER_ENABLE_BIT) & {16{ext_trigger_enable_q}};  // see R11, R21

    // Sequencer hookup
    assign sq.trig      = conv_trig;
    assign sq.abort     = ext_en_rise && conv_repeat_mode_q;                     // see R20
    assign sq.auto_mode = auto_mode;
    // Bypass so a control write starts from its own first channel, not the stale one
    assign wr_first     = adc_ctrl_wdata[`ACR_FIRST_LSB +: 4];
    assign sq.first     = adc_ctrl_wr ? wr_first : first_channel_addr_q;         // see R16
    assign sq.last      = last_channel_addr_q;
    assign sq.chan_done = adc_chan_done;

    conv_sequencer u_seq (
        .clk     (clk),
        .reset_n (reset_n),
        .sq      (sq)
    );

    drdy_pulse_gen #(
        .WIDTH_CYC (DRDY_PULSE_CYC)
    ) u_pulse (
        .clk     (clk),
        .reset_n (reset_n),
        .fire    (pulse_fire),
        .active  (pulse_active)
    );

    // Status/configuration register; config bits change only on reset and host writes, the data-ready flag also on group done, data reads and conversion starts
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            reset_done_flag_q      <= `SCR_RESET_DONE_FLAG_RST;   // see R1, R19
            conv_data_ready_flag_q <= `SCR_CONV_DATA_READY_FLAG_RST;
            ext_ref_select_q       <= `SCR_EXT_REF_SELECT_RST;
            int_ref_gain_select_q  <= `SCR_INT_REF_GAIN_SELECT_RST;
            ext_trigger_enable_q   <= `SCR_EXT_TRIGGER_ENABLE_RST;
        end else begin
            reset_done_flag_q      <= reset_done_flag_d;
            conv_data_ready_flag_q <= flag_d;
            if (scr_wr) begin
                ext_ref_select_q      <= scr_wdata[`SCR_EXT_REF_SELECT_BIT];   // see R12
                int_ref_gain_select_q <= scr_wdata[`SCR_INT_REF_GAIN_SELECT_BIT];   // see R13
                ext_trigger_enable_q  <= scr_wdata[`SCR_EXT_TRIGGER_ENABLE_BIT];
            end
        end
    end

    // ADC control fields kept here for group selection and mode decode
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            conv_repeat_mode_q   <= `CONV_REPEAT_MODE_RST;
            first_channel_addr_q <= 4'h0;
            last_channel_addr_q  <= 4'h0;
        end else begin
            if (adc_ctrl_wr) begin
                first_channel_addr_q <= adc_ctrl_wdata[`ACR_FIRST_LSB +: 4];
                last_channel_addr_q  <= adc_ctrl_wdata[`ACR_LAST_LSB +: 4];
            end
            if (ext_trigger_enable_q || ext_en_rise) begin
                conv_repeat_mode_q <= 1'b0;                        // see R20
            end else if (adc_ctrl_wr) begin
                conv_repeat_mode_q <= adc_ctrl_wdata[`ACR_CONV_REPEAT_MODE_BIT];
            end
        end
    end

    // Pins and analog controls; DAC shift register lives outside, resets skip it  // see R2
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            convert_pin_q  <= 1'b0;
            drdy_pin_q     <= 1'b1;
            scr_rdata_q    <= 16'h0000;
            adc_start_q    <= 1'b0;
            adc_chan_q     <= 4'h0;
            isrc_ref_cfg_q <= 2'h0;
            powered_down_q <= 1'b1;                                 // see R4
        end else begin
            convert_pin_q  <= convert_pin;
            drdy_pin_q     <= auto_mode ? !pulse_active             // see R9
                                        : !conv_data_ready_flag_q;  // see R8
            scr_rdata_q    <= scr_word;
            adc_start_q    <= sq.start;
            adc_chan_q     <= sq.chan;
            isrc_ref_cfg_q <= {ext_ref_select_q, int_ref_gain_select_q};  // see R14
            if (pd_reg_wr) begin
                powered_down_q <= 1'b0;                             // see R4
            end
        end
    end

    assign data_ready_pin_n    = drdy_pin_q;
    assign ext_ref_select      = ext_ref_select_q;
    assign int_ref_gain_select = int_ref_gain_select_q;

    // Checks
    sequence host_clears_reset_done_flag;
        scr_wr && !scr_wdata[`SCR_RESET_DONE_FLAG_BIT];
    endsequence

    reset_done_flag_clear_a: assert property (@(posedge clk) disable iff (!reset_n)  // see R5
        host_clears_reset_done_flag |=> !reset_done_flag_q [*2])
        else $error("Reset-done flag not cleared by host write");

    reset_done_flag_hold_a: assert property (@(posedge clk) disable iff (!reset_n)  // see R5
        (reset_done_flag_q && !(scr_wr && !scr_wdata[`SCR_RESET_DONE_FLAG_BIT])) |=> reset_done_flag_q)
        else $error("Reset-done flag dropped without a zero write");

    reset_done_flag_reset_a: assert property (@(posedge clk)  // see R19
        !reset_n |=> (reset_done_flag_q && !conv_data_ready_flag_q && !ext_ref_select_q
                      && !int_ref_gain_select_q && !ext_trigger_enable_q && powered_down_q))
        else $error("Wrong values after reset");

    flag_auto_zero_a: assert property (@(posedge clk) disable iff (!reset_n)  // see R7
        auto_mode |=> !conv_data_ready_flag_q)
        else $error("Data-ready flag set in auto mode");

    flag_set_a: assert property (@(posedge clk) disable iff (!reset_n)  // see R6
        (sq.set_done && !auto_mode) |=> conv_data_ready_flag_q)
        else $error("Group completion did not raise flag");

    flag_clear_a: assert property (@(posedge clk) disable iff (!reset_n)  // see R10
        (adc_data_rd && !flag_set) |=> !conv_data_ready_flag_q)
        else $error("Data read did not clear flag");

    pin_mirror_a: assert property (@(posedge clk) disable iff (!reset_n)  // see R8
        (!auto_mode && !$past(auto_mode)) |=> (data_ready_pin_n == !$past(conv_data_ready_flag_q)))
        else $error("Pin does not mirror flag in direct mode");

    sequence auto_fire;
        pulse_fire ##1 !pulse_fire [*2];
    endsequence

    pin_pulse_a: assert property (@(posedge clk) disable iff (!reset_n)  // see R9
        (auto_fire ##0 auto_mode [*1]) |=> !data_ready_pin_n)
        else $error("No low pulse after last channel in auto mode");

    ext_ignored_a: assert property (@(posedge clk) disable iff (!reset_n)  // see R17
        (!ext_trigger_enable_q && !adc_ctrl_wr) |-> !conv_trig)
        else $error("Trigger pin acted while disabled");

    ctrl_wr_nostart_a: assert property (@(posedge clk) disable iff (!reset_n)  // see R15
        (ext_trigger_enable_q && adc_ctrl_wr && !ext_edge) |-> !sq.trig)
        else $error("Control write started conversion in external mode");

    zero_bits_a: assert property (@(posedge clk) disable iff (!reset_n)  // see R11
        scr_rdata_q[`SCR_ZERO_BIT] == 1'b0 && scr_rdata_q[15] == 1'b0 && scr_rdata_q[4:0] == 5'h00)
        else $error("Reserved status bits read non-zero");

    first_chan_new_a: assert property (@(posedge clk) disable iff (!reset_n)  // see R16
        (int_trig && !sq.abort) |=> ##1 (adc_start_q && adc_chan_q == $past(wr_first, 2)))
        else $error("Control write did not start at its first channel");

    conv_repeat_mode_forced_a: assert property (@(posedge clk) disable iff (!reset_n)  // see R20
        ext_trigger_enable_q |=> !conv_repeat_mode_q)
        else $error("Repeat mode held with external trigger");

endmodule : monitor_status_config_regs
`default_nettype wire

// ==== dv/adc_model.sv ====
// Purpose: Behavioural ADC that answers each conversion start with a done pulse, unless a new start comes first.
// Assumes: Start is a one-cycle pulse; a new start restarts the conversion.
// Notes:   Slow mode stretches conversions past the auto-mode pin pulse.
`timescale 1ns/1ps
`default_nettype none
module adc_model (
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    // Conversion handshake
    input  wire logic start,
    input  wire logic slow,
    output logic      done_q
);
    logic [7:0] cnt_q;

    // Done only ever follows a start, never spontaneously
    always_ff @(posedge clk) begin
        done_q <= 1'b0;
        if (!reset_n) begin
            cnt_q <= 8'h00;
        end else if (start) begin
            cnt_q <= slow ? 8'h14 : 8'h03;
        end else if (cnt_q == 8'h01) begin
            cnt_q  <= 8'h00;
            done_q <= 1'b1;
        end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
        end
    end
endmodule : adc_model
`default_nettype wire

// ==== dv/monitor_status_config_regs_tb.sv ====
// Purpose: Self-checking bench for the status/config register block.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes:   Pulse width shortened to 8 cycles to keep the run brief.
`timescale 1ns/1ps
`default_nettype none
module monitor_status_config_regs_tb;
    localparam int unsigned PULSE = 8;

    logic        clk, reset_n, scr_wr, adc_ctrl_wr, adc_data_rd, pd_reg_wr;
    logic        convert_pin, adc_chan_done, slow, adc_start_q, data_ready_pin_n;
    logic        ext_ref_select, int_ref_gain_select, powered_down_q;
    logic [15:0] scr_wdata, adc_ctrl_wdata, scr_rdata_q;
    logic [3:0]  adc_chan_q, last_chan;
    logic [1:0]  isrc_ref_cfg_q;
    int          miscompares, compares, starts;

    monitor_status_config_regs #(.DRDY_PULSE_CYC(PULSE)) dut_u (
        .clk(clk), .reset_n(reset_n), .scr_wr(scr_wr), .scr_wdata(scr_wdata),
        .scr_rdata_q(scr_rdata_q), .adc_ctrl_wr(adc_ctrl_wr), .adc_ctrl_wdata(adc_ctrl_wdata),
        .adc_data_rd(adc_data_rd), .pd_reg_wr(pd_reg_wr), .convert_pin(convert_pin),
        .adc_chan_done(adc_chan_done), .adc_start_q(adc_start_q), .adc_chan_q(adc_chan_q),
        .data_ready_pin_n(data_ready_pin_n), .ext_ref_select(ext_ref_select),
        .int_ref_gain_select(int_ref_gain_select), .isrc_ref_cfg_q(isrc_ref_cfg_q),
        .powered_down_q(powered_down_q));

    adc_model model_u (.clk(clk), .reset_n(reset_n), .start(adc_start_q), .slow(slow),
        .done_q(adc_chan_done));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk) begin
        if (adc_start_q === 1'b1) begin
            starts    <= starts + 1;
            last_chan <= adc_chan_q;
        end
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    task automatic check16(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check16

    task automatic check1(input string what, input logic exp, input logic got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask : check1

    task automatic scr_write(input logic [15:0] d);
        scr_wdata = d;
        scr_wr = 1'b1;
        step(1);
        scr_wr = 1'b0;
        step(2);
    endtask : scr_write

    task automatic ctrl_write(input logic [15:0] d);
        adc_ctrl_wdata = d;
        adc_ctrl_wr = 1'b1;
        step(1);
        adc_ctrl_wr = 1'b0;
    endtask : ctrl_write

    task automatic read_clear();
        adc_data_rd = 1'b1;
        step(1);
        adc_data_rd = 1'b0;
        step(3);
    endtask : read_clear

    // Bounded, so a dead sequencer shows up as a mismatch, not a hang
    task automatic wait_pin_low();
        int n;
        n = 0;
        while (data_ready_pin_n !== 1'b0 && n < 1000) begin
            n++;
            step(1);
        end
        check1("pin low within limit", 1'b1, n < 1000);
    endtask : wait_pin_low

    task automatic test_reset_values();
        check16("word after reset", 16'h4000, scr_rdata_q);
        check1("pin after reset", 1'b1, data_ready_pin_n);
        check1("ext ref after reset", 1'b0, ext_ref_select);
        check1("gain after reset", 1'b0, int_ref_gain_select);
        check1("powered down after reset", 1'b1, powered_down_q);
        pd_reg_wr = 1'b1;
        step(1);
        pd_reg_wr = 1'b0;
        step(2);
        check1("powered down after pd write", 1'b0, powered_down_q);
    endtask : test_reset_values

    task automatic test_field_access();
        scr_write(16'hffff);
        check16("word all ones", 16'h40e0, scr_rdata_q);
        check1("ext ref set", 1'b1, ext_ref_select);
        check1("gain set", 1'b1, int_ref_gain_select);
        check16("isrc cfg", 16'h0003, {14'h0000, isrc_ref_cfg_q});
        scr_write(16'hff1f);
        check16("keep with one", 16'h4000, scr_rdata_q);
        scr_write(16'h0040);
        check16("gain only", 16'h0040, scr_rdata_q);
        check16("isrc gain only", 16'h0001, {14'h0000, isrc_ref_cfg_q});
        scr_write(16'h6000);
        check16("host cannot set flags", 16'h0000, scr_rdata_q);
    endtask : test_field_access

    task automatic test_direct_conv();
        int s0;
        slow = 1'b0;
        s0 = starts;
        convert_pin = 1'b1;
        step(10);
        convert_pin = 1'b0;
        step(10);
        check16("pin ignored", 16'(s0), 16'(starts));
        ctrl_write(16'h0240);
        wait_pin_low();
        check16("channels converted", 16'h0003, 16'(starts - s0));
        check16("last channel", 16'h0004, {12'h000, last_chan});
        check16("flag after group", 16'h2000, scr_rdata_q);
        read_clear();
        check16("flag after data read", 16'h0000, scr_rdata_q);
        check1("pin after data read", 1'b1, data_ready_pin_n);
        ctrl_write(16'h0240);
        wait_pin_low();
        scr_write(16'h0000);
        step(1);
        check16("flag after zero write", 16'h0000, scr_rdata_q);
        check1("pin after zero write", 1'b1, data_ready_pin_n);
        slow = 1'b1;
        ctrl_write(16'h0240);
        wait_pin_low();
        ctrl_write(16'h0240);
        step(3);
        check16("flag after new start", 16'h0000, scr_rdata_q);
        wait_pin_low();
        read_clear();
    endtask : test_direct_conv

    task automatic test_auto_conv();
        int n;
        slow = 1'b1;
        ctrl_write(16'h8110);
        wait_pin_low();
        check16("flag in auto", 16'h0000, scr_rdata_q);
        n = 0;
        while (data_ready_pin_n === 1'b0 && n < 100) begin
            n++;
            step(1);
        end
        check16("auto pulse width", 16'(PULSE), 16'(n));
        wait_pin_low();
        check16("flag in auto repeat", 16'h0000, scr_rdata_q);
        // Leave the pulse behind before switching, so the next low is the flag
        step(12);
        ctrl_write(16'h0110);
        wait_pin_low();
        check16("flag back in direct", 16'h2000, scr_rdata_q);
        read_clear();
    endtask : test_auto_conv

    task automatic test_ext_trigger();
        int s0;
        scr_write(16'h0020);
        check16("trigger enable stored", 16'h0020, scr_rdata_q);
        s0 = starts;
        ctrl_write(16'h8230);
        step(40);
        check16("no start on control write", 16'(s0), 16'(starts));
        convert_pin = 1'b1;
        wait_pin_low();
        check16("ext channels", 16'h0002, 16'(starts - s0));
        check16("ext last channel", 16'h0003, {12'h000, last_chan});
        check16("ext forces direct", 16'h2020, scr_rdata_q);
        step(60);
        check16("idle after group", 16'(s0 + 2), 16'(starts));
        convert_pin = 1'b0;
        read_clear();
        scr_write(16'h0000);
    endtask : test_ext_trigger

    task automatic test_mid_reset();
        int s0;
        scr_write(16'h00c0);
        ctrl_write(16'h8110);
        step(5);
        reset_n = 1'b0;
        step(2);
        reset_n = 1'b1;
        step(2);
        s0 = starts;
        check16("word after mid reset", 16'h4000, scr_rdata_q);
        check1("ext ref after mid reset", 1'b0, ext_ref_select);
        check16("isrc after mid reset", 16'h0000, {14'h0000, isrc_ref_cfg_q});
        check1("powered down again", 1'b1, powered_down_q);
        step(50);
        check16("no run after reset", 16'(s0), 16'(starts));
        check1("pin idle after reset", 1'b1, data_ready_pin_n);
    endtask : test_mid_reset

    task automatic give_verdict();
        if (miscompares == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : give_verdict

    initial begin
        #80000;
        miscompares++;
        give_verdict();
    end

    initial begin
        miscompares = 0;
        compares = 0;
        starts = 0;
        last_chan = 4'h0;
        reset_n = 1'b0;
        scr_wr = 1'b0;
        scr_wdata = 16'h0000;
        adc_ctrl_wr = 1'b0;
        adc_ctrl_wdata = 16'h0000;
        adc_data_rd = 1'b0;
        pd_reg_wr = 1'b0;
        convert_pin = 1'b0;
        slow = 1'b0;
        step(20);
        reset_n = 1'b1;
        step(2);
        test_reset_values();
        test_field_access();
        test_direct_conv();
        test_auto_conv();
        test_ext_trigger();
        test_mid_reset();
        give_verdict();
    end
endmodule : monitor_status_config_regs_tb
`default_nettype wire
